/* rtl/pdm_pkg.sv */
// Operation
// - three-bit drive field per pin
// - mode 0 disables driver and input; reset
// - mode 1 digital input, driver off
// - modes 2,3 resistive one side, strong other
// - mode 4 hi-Z high, strong low
// - mode 5 strong high, hi-Z low
// - mode 6 strong both states
// - mode 7 pull-up high, pull-down low
// - bypass selects fabric data over register
// - pad level feeds pin state and fabric
// - pin state separate from output data
// - per-pin rising, falling or both edges
// - edge sets status bit, requests interrupt
// - one interrupt line per port
// - level interrupts left to fabric logic
// - port-wide and per-pin writes share storage
// - reset drive state is software programmable
// - usb pins: drive enable gives strong outputs
// - usb pins: pull enable selects pull-up/float
// - usb mode ignores usb drive bits
// - port-wide writes skip usb drive bits
// - no resistive modes in regulated output
// - mode 0 gives no digital input
package pdm_pkg;
   localparam int          NPINS       = 8;         // pins in the port
   localparam int          NUSB        = 2;         // usb capable pins
   localparam int          AW          = 8;         // register address width
   localparam int          DW          = 32;        // register data width
   // register byte offsets
   localparam logic [7:0]  ADDR_DR     = 8'h00;     // output data, port form
   localparam logic [7:0]  ADDR_PS     = 8'h04;     // pin state, read only
   localparam logic [7:0]  ADDR_DM0    = 8'h08;     // drive field bit 0, port form
   localparam logic [7:0]  ADDR_DM1    = 8'h0C;     // drive field bit 1, port form
   localparam logic [7:0]  ADDR_DM2    = 8'h10;     // drive field bit 2, port form
   localparam logic [7:0]  ADDR_BYP    = 8'h14;     // hardware bypass select
   localparam logic [7:0]  ADDR_RISE   = 8'h18;     // rising edge enable
   localparam logic [7:0]  ADDR_FALL   = 8'h1C;     // falling edge enable
   localparam logic [7:0]  ADDR_INTST  = 8'h20;     // interrupt status, write one to clear
   localparam logic [7:0]  ADDR_ROUTE  = 8'h24;     // input routed to fabric
   localparam logic [7:0]  ADDR_REGOUT = 8'h28;     // regulated output level select
   localparam logic [7:0]  ADDR_RSTDM  = 8'h2C;     // programmable port reset drive fields
   localparam logic [7:0]  ADDR_CTRL   = 8'h30;     // control, write only
   localparam logic [7:0]  ADDR_USB    = 8'h34;     // usb capable pin control
   localparam logic [7:0]  ADDR_PIN0   = 8'h40;     // first pin form register
   localparam logic [7:0]  PIN_STRIDE  = 8'h04;     // pin form spacing
   // pin form field positions
   localparam int          PF_DR       = 0;
   localparam int          PF_DM       = 1;         // three bits
   localparam int          PF_BYP      = 4;
   localparam int          PF_RISE     = 5;
   localparam int          PF_FALL     = 6;
   localparam int          PF_ROUTE    = 7;
   localparam int          PF_PS       = 8;         // read only
   // control and usb field positions
   localparam int          CTRL_RELOAD = 0;         // load drive fields from reset state
   localparam int          USB_MODE    = 0;
   localparam int          USB_DRV     = 1;         // two bits
   localparam int          USB_PULL    = 3;         // two bits
   localparam int          USB_DATA    = 5;         // two bits
   localparam int          USB_PS      = 7;         // two bits, read only
   // drive field encodings
   localparam logic [2:0]  DM_ANALOG   = 3'h0;
   localparam logic [2:0]  DM_DIGIN    = 3'h1;
   localparam logic [2:0]  DM_RES_UP   = 3'h2;
   localparam logic [2:0]  DM_RES_DN   = 3'h3;
   localparam logic [2:0]  DM_OD_LOW   = 3'h4;
   localparam logic [2:0]  DM_OD_HIGH  = 3'h5;
   localparam logic [2:0]  DM_STRONG   = 3'h6;
   localparam logic [2:0]  DM_RES_BOTH = 3'h7;
   localparam logic [2:0]  DM_RESET    = DM_ANALOG; // hard reset drive field
   localparam logic [23:0] RSTDM_RESET = 24'h000000;

   // pad driver controls for one pin
   typedef struct packed {
      logic out;                                    // level when strong drive enabled
      logic oe;                                     // strong driver on
      logic pu;                                     // resistive pull-up on
      logic pd;                                     // resistive pull-down on
   } pdm_drive_type;
endpackage

/* rtl/pdm_port.sv */
`timescale 1ns/1ps
module pdm_port
(
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic [pdm_pkg::AW-1:0]   reg_addr,
   input  wire logic [pdm_pkg::DW-1:0]   reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [pdm_pkg::DW-1:0]   reg_rdata,
   input  wire logic [pdm_pkg::NPINS-1:0] pad_in,
   output logic      [pdm_pkg::NPINS-1:0] pad_out,
   output logic      [pdm_pkg::NPINS-1:0] pad_oe,
   output logic      [pdm_pkg::NPINS-1:0] pad_pu,
   output logic      [pdm_pkg::NPINS-1:0] pad_pd,
   input  wire logic [pdm_pkg::NPINS-1:0] fabric_out,
   output logic      [pdm_pkg::NPINS-1:0] fabric_in,
   output logic                          port_irq,
   input  wire logic [pdm_pkg::NUSB-1:0] usb_pad_in,
   output logic      [pdm_pkg::NUSB-1:0] usb_pad_out,
   output logic      [pdm_pkg::NUSB-1:0] usb_pad_oe,
   output logic      [pdm_pkg::NUSB-1:0] usb_pad_pu,
   input  wire logic [pdm_pkg::NUSB-1:0] usb_core_out,
   input  wire logic [pdm_pkg::NUSB-1:0] usb_core_oe
);
   import pdm_pkg::*;

   // decode of one drive field and data bit into pad controls
   function automatic pdm_drive_type drive_decode(input logic [2:0] m, input logic d, input logic reg_lvl);
      pdm_drive_type r;
      r = '0;
      unique case (m)
         DM_ANALOG, DM_DIGIN : r = '0;
         DM_RES_UP   : r = '{out: 1'b0, oe: ~d,   pu: d,    pd: 1'b0};
         DM_RES_DN   : r = '{out: d,    oe: d,    pu: 1'b0, pd: ~d};
         DM_OD_LOW   : r = '{out: 1'b0, oe: ~d,   pu: 1'b0, pd: 1'b0};
         DM_OD_HIGH  : r = '{out: d,    oe: d,    pu: 1'b0, pd: 1'b0};
         DM_STRONG   : r = '{out: d,    oe: 1'b1, pu: 1'b0, pd: 1'b0};
         DM_RES_BOTH : r = '{out: 1'b0, oe: 1'b0, pu: d,    pd: ~d};
      endcase
      // resistive legs are cut while the pin sits at the regulated level
      if (reg_lvl)
      begin
         r.pu = 1'b0;
         r.pd = 1'b0;
      end
      return r;
   endfunction

   // usb capable pin decode; usb mode hands the pad to the usb core
   function automatic pdm_drive_type usb_decode(input logic mode, input logic drv, input logic pull,
                                               input logic d, input logic core_d, input logic core_oe);
      pdm_drive_type r;
      r = '0;
      if (mode)
      begin
         r.oe  = core_oe;
         r.out = core_d;
      end
      else if (drv)
      begin
         r.oe  = 1'b1;
         r.out = d;
      end
      else if (!d)
         r.oe = 1'b1;
      else
         r.pu = pull;
      return r;
   endfunction

   // configuration storage; drive, data, bypass, edge and route fields shared by port form and pin form writes
   logic [NPINS-1:0][2:0] dm_r, dm_nxt;       // drive fields
   logic [NPINS-1:0]      dr_r, dr_nxt;       // output data register
   logic [NPINS-1:0]      byp_r, byp_nxt;     // hardware bypass
   logic [NPINS-1:0]      rise_r, rise_nxt;   // rising edge enable
   logic [NPINS-1:0]      fall_r, fall_nxt;   // falling edge enable
   logic [NPINS-1:0]      route_r, route_nxt; // input routed to fabric
   logic [NPINS-1:0]      regout_r;           // regulated output level
   logic [23:0]           rstdm_r;            // reset drive fields
   logic [NPINS-1:0]      intst_r, intst_nxt; // sticky interrupt status
   logic                  usb_mode_r;         // usb pins owned by usb core
   logic [NUSB-1:0]       usb_drv_r;          // usb drive enable
   logic [NUSB-1:0]       usb_pull_r;         // usb pull enable
   logic [NUSB-1:0]       usb_dat_r;          // usb output data
   // input path
   logic [NPINS-1:0]      s1_r, s2_r, s3_r;   // pad synchroniser
   logic [NPINS-1:0]      filt_r;             // agreed pad level
   logic [NPINS-1:0]      ps_r;               // pin state register
   logic [NPINS-1:0]      ps_prev_r;          // previous pin state for edges
   logic [NUSB-1:0]       u1_r, u2_r, u3_r;   // usb pad synchroniser
   logic [NUSB-1:0]       ufilt_r;            // agreed usb pad level
   // driver and bus outputs
   pdm_drive_type [NPINS-1:0] drv_r;          // registered pad controls
   pdm_drive_type [NUSB-1:0]  udrv_r;         // registered usb pad controls
   logic [DW-1:0]         rdata_r, rdata_nxt; // read data, valid one cycle after strobe
   logic [NPINS-1:0]      fab_r;              // input to fabric
   logic                  irq_r;              // port interrupt line

   // port-form write decode
   wire wr_dr     = reg_wr && (reg_addr == ADDR_DR);
   wire wr_dm0    = reg_wr && (reg_addr == ADDR_DM0);
   wire wr_dm1    = reg_wr && (reg_addr == ADDR_DM1);
   wire wr_dm2    = reg_wr && (reg_addr == ADDR_DM2);
   wire wr_byp    = reg_wr && (reg_addr == ADDR_BYP);
   wire wr_rise   = reg_wr && (reg_addr == ADDR_RISE);
   wire wr_fall   = reg_wr && (reg_addr == ADDR_FALL);
   wire wr_intst  = reg_wr && (reg_addr == ADDR_INTST);
   wire wr_route  = reg_wr && (reg_addr == ADDR_ROUTE);
   wire wr_regout = reg_wr && (reg_addr == ADDR_REGOUT);
   wire wr_rstdm  = reg_wr && (reg_addr == ADDR_RSTDM);
   wire wr_usb    = reg_wr && (reg_addr == ADDR_USB);
   wire reload    = reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_RELOAD];

   // input gating: mode 0 kills the digital input buffer
   wire [NPINS-1:0] in_en;
   wire [NPINS-1:0] ps_nxt;
   wire [NPINS-1:0] rise_ev;
   wire [NPINS-1:0] fall_ev;
   wire [NPINS-1:0] int_set;
   wire [NPINS-1:0] out_val;
   wire [NPINS-1:0] pin_hit;
   logic [DW-1:0]   pin_rd [NPINS];

   genvar i;
   generate
      for (i = 0; i < NPINS; i++)
      begin : g_pin
         localparam logic [7:0] PADDR = ADDR_PIN0 + 8'(i) * PIN_STRIDE;
         wire pin_wr = reg_wr && (reg_addr == PADDR);
         assign pin_hit[i] = (reg_addr == PADDR);
         // pin form and port form land in the same flops; pin form wins a tie that cannot occur
         assign dr_nxt[i]    = pin_wr ? reg_wdata[PF_DR]    : wr_dr    ? reg_wdata[i] : dr_r[i];
         assign byp_nxt[i]   = pin_wr ? reg_wdata[PF_BYP]   : wr_byp   ? reg_wdata[i] : byp_r[i];
         assign rise_nxt[i]  = pin_wr ? reg_wdata[PF_RISE]  : wr_rise  ? reg_wdata[i] : rise_r[i];
         assign fall_nxt[i]  = pin_wr ? reg_wdata[PF_FALL]  : wr_fall  ? reg_wdata[i] : fall_r[i];
         assign route_nxt[i] = pin_wr ? reg_wdata[PF_ROUTE] : wr_route ? reg_wdata[i] : route_r[i];
         assign dm_nxt[i]    = reload ? rstdm_r[i*3 +: 3] :
                               pin_wr ? reg_wdata[PF_DM +: 3] :
                               {wr_dm2 ? reg_wdata[i] : dm_r[i][2],
                                wr_dm1 ? reg_wdata[i] : dm_r[i][1],
                                wr_dm0 ? reg_wdata[i] : dm_r[i][0]};
         assign in_en[i]   = (dm_r[i] != DM_ANALOG);
         assign ps_nxt[i]  = in_en[i] & filt_r[i];
         assign out_val[i] = byp_r[i] ? fabric_out[i] : dr_r[i];
         // edge compare of the pin state against its previous sample
         assign rise_ev[i] = ps_r[i] & ~ps_prev_r[i];
         assign fall_ev[i] = ~ps_r[i] & ps_prev_r[i];
         assign int_set[i] = (rise_ev[i] & rise_r[i]) | (fall_ev[i] & fall_r[i]);
         // pin form read view
         assign pin_rd[i] = DW'({ps_r[i], route_r[i], fall_r[i], rise_r[i], byp_r[i], dm_r[i], dr_r[i]});
      end
   endgenerate

   // status: a new edge wins over a clear in the same cycle
   assign intst_nxt = (intst_r & ~(wr_intst ? reg_wdata[NPINS-1:0] : '0)) | int_set;

   // read mux, selected by address; unmapped locations read zero
   logic [DW-1:0] pin_sel;
   always_comb
   begin
      pin_sel = '0;
      for (int k = 0; k < NPINS; k++)
         if (pin_hit[k])
            pin_sel = pin_rd[k];
   end
   always_comb
   begin
      unique case (reg_addr)
         ADDR_DR     : rdata_nxt = DW'(dr_r);
         ADDR_PS     : rdata_nxt = DW'(ps_r);
         ADDR_DM0    : rdata_nxt = DW'({dm_r[7][0], dm_r[6][0], dm_r[5][0], dm_r[4][0],
                                        dm_r[3][0], dm_r[2][0], dm_r[1][0], dm_r[0][0]});
         ADDR_DM1    : rdata_nxt = DW'({dm_r[7][1], dm_r[6][1], dm_r[5][1], dm_r[4][1],
                                        dm_r[3][1], dm_r[2][1], dm_r[1][1], dm_r[0][1]});
         ADDR_DM2    : rdata_nxt = DW'({dm_r[7][2], dm_r[6][2], dm_r[5][2], dm_r[4][2],
                                        dm_r[3][2], dm_r[2][2], dm_r[1][2], dm_r[0][2]});
         ADDR_BYP    : rdata_nxt = DW'(byp_r);
         ADDR_RISE   : rdata_nxt = DW'(rise_r);
         ADDR_FALL   : rdata_nxt = DW'(fall_r);
         ADDR_INTST  : rdata_nxt = DW'(intst_r);
         ADDR_ROUTE  : rdata_nxt = DW'(route_r);
         ADDR_REGOUT : rdata_nxt = DW'(regout_r);
         ADDR_RSTDM  : rdata_nxt = DW'(rstdm_r);
         ADDR_USB    : rdata_nxt = DW'({ufilt_r, usb_dat_r, usb_pull_r, usb_drv_r, usb_mode_r});
         default     : rdata_nxt = pin_sel;
      endcase
   end

   // configuration registers; port-wide drive writes never touch usb bits
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         dm_r    <= {NPINS{DM_RESET}};
         dr_r    <= '0;
         byp_r   <= '0;
         rise_r  <= '0;
         fall_r  <= '0;
         route_r <= '0;
         intst_r <= '0;
      end
      else
      begin
         dm_r    <= dm_nxt;
         dr_r    <= dr_nxt;
         byp_r   <= byp_nxt;
         rise_r  <= rise_nxt;
         fall_r  <= fall_nxt;
         route_r <= route_nxt;
         intst_r <= intst_nxt;
      end
   end

   // port-level options and the separate usb pin control word
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         regout_r   <= '0;
         rstdm_r    <= RSTDM_RESET;
         usb_mode_r <= 1'b0;
         usb_drv_r  <= '0;
         usb_pull_r <= '0;
         usb_dat_r  <= '0;
      end
      else
      begin
         if (wr_regout)
            regout_r <= reg_wdata[NPINS-1:0];
         if (wr_rstdm)
            rstdm_r <= reg_wdata[23:0];
         if (wr_usb)
         begin
            usb_mode_r <= reg_wdata[USB_MODE];
            usb_drv_r  <= reg_wdata[USB_DRV +: NUSB];
            usb_pull_r <= reg_wdata[USB_PULL +: NUSB];
            usb_dat_r  <= reg_wdata[USB_DATA +: NUSB];
         end
      end
   end

   // pad synchronisers; a level counts once stages two and three agree
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         {s1_r, s2_r, s3_r, filt_r} <= '0;
         {u1_r, u2_r, u3_r, ufilt_r} <= '0;
      end
      else
      begin
         s1_r <= pad_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= (s2_r == s3_r) ? s3_r : filt_r;
         u1_r <= usb_pad_in;
         u2_r <= u1_r;
         u3_r <= u2_r;
         ufilt_r <= (u2_r == u3_r) ? u3_r : ufilt_r;
      end
   end

   // pin state, fabric input, edge history and the single port interrupt
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ps_r      <= '0;
         ps_prev_r <= '0;
         fab_r     <= '0;
         irq_r     <= 1'b0;
      end
      else
      begin
         ps_r      <= ps_nxt;
         ps_prev_r <= ps_r;
         fab_r     <= ps_nxt & route_r;
         irq_r     <= |intst_nxt;
      end
   end

   // registered pad drivers; decode is one cycle behind configuration
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         drv_r   <= '0;
         udrv_r  <= '0;
         rdata_r <= '0;
      end
      else
      begin
         for (int k = 0; k < NPINS; k++)
            drv_r[k] <= drive_decode(dm_r[k], out_val[k], regout_r[k]);
         for (int k = 0; k < NUSB; k++)
            udrv_r[k] <= usb_decode(usb_mode_r, usb_drv_r[k], usb_pull_r[k], usb_dat_r[k],
                                    usb_core_out[k], usb_core_oe[k]);
         rdata_r <= reg_rd ? rdata_nxt : '0;
      end
   end

   // level interrupts are not detected here; fabric logic builds them from fabric_in
   generate
      for (i = 0; i < NPINS; i++)
      begin : g_out
         assign pad_out[i] = drv_r[i].out;
         assign pad_oe[i]  = drv_r[i].oe;
         assign pad_pu[i]  = drv_r[i].pu;
         assign pad_pd[i]  = drv_r[i].pd;
      end
      for (i = 0; i < NUSB; i++)
      begin : g_usb
         assign usb_pad_out[i] = udrv_r[i].out;
         assign usb_pad_oe[i]  = udrv_r[i].oe;
         assign usb_pad_pu[i]  = udrv_r[i].pu;
      end
   endgenerate
   assign fabric_in = fab_r;
   assign port_irq  = irq_r;
   assign reg_rdata = rdata_r;

   // checks on pins 0, 1 and 5 and usb pin 0; each pin is one the tests actually exercise
   property p_mode0_off;
      @(posedge clock) disable iff (rst)
      (dm_r[0] == DM_ANALOG) |=> (!pad_oe[0] && !pad_pu[0] && !pad_pd[0] && !ps_r[0] && !fabric_in[0]);
   endproperty
   a_mode0_off: assert property (p_mode0_off) else $error("mode 0 pin not fully off");

   property p_od_low;
      @(posedge clock) disable iff (rst)
      (dm_r[0] == DM_OD_LOW) |=> (pad_oe[0] == !$past(out_val[0])) && !pad_out[0];
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain low wrong");

   property p_od_high;
      @(posedge clock) disable iff (rst)
      (dm_r[0] == DM_OD_HIGH) |=> (pad_oe[0] == $past(out_val[0])) && !pad_pu[0] && !pad_pd[0];
   endproperty
   a_od_high: assert property (p_od_high) else $error("open drain high wrong");

   property p_bypass_strong;
      @(posedge clock) disable iff (rst)
      (dm_r[5] == DM_STRONG && byp_r[5]) |=> pad_oe[5] && (pad_out[5] == $past(fabric_out[5]));
   endproperty
   a_bypass_strong: assert property (p_bypass_strong) else $error("bypass data not driven");

   property p_res_both;
      @(posedge clock) disable iff (rst)
      (dm_r[0] == DM_RES_BOTH && !regout_r[0]) |=> (pad_pu[0] == $past(out_val[0]))
                                                   && (pad_pd[0] != $past(out_val[0])) && !pad_oe[0];
   endproperty
   a_res_both: assert property (p_res_both) else $error("pull up/down mode wrong");

   property p_regulated;
      @(posedge clock) disable iff (rst)
      regout_r[0] |=> !pad_pu[0] && !pad_pd[0];
   endproperty
   a_regulated: assert property (p_regulated) else $error("pull active in regulated mode");

   property p_rise_sets;
      @(posedge clock) disable iff (rst)
      (rise_ev[1] && rise_r[1]) |=> intst_r[1] && port_irq;
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

   property p_sticky;
      @(posedge clock) disable iff (rst)
      (intst_r[1] && !(wr_intst && reg_wdata[1])) |=> intst_r[1];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit dropped");

   property p_usb_strong;
      @(posedge clock) disable iff (rst)
      (!usb_mode_r && usb_drv_r[0]) |=> usb_pad_oe[0] && (usb_pad_out[0] == $past(usb_dat_r[0]));
   endproperty
   a_usb_strong: assert property (p_usb_strong) else $error("usb strong drive wrong");
endmodule

/* sim/pdm_board.sv */
`timescale 1ns/1ps
module pdm_board
(
   input  wire logic       clock,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pad_pu,
   input  wire logic [7:0] pad_pd,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   output logic      [7:0] pad_in
);
   logic [7:0] last_r = 8'h00; // last wire level
   // strong leg wins, then board drive holding a rail, then pulls; a floating wire drifts
   always_comb
      for (int i = 0; i < 8; i++)
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                     pad_pu[i] ? 1'b1 : pad_pd[i] ? 1'b0 : ~last_r[i];
   // remember the level so a floating wire never looks settled
   always_ff @(posedge clock)
      last_r <= pad_in;
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import pdm_pkg::*;
   logic          clock = 1'b0;
   logic          rst = 1'b1;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic [DW-1:0] reg_rdata, rd_v;
   logic [7:0]    pad_in, pad_out, pad_oe, pad_pu, pad_pd, fabric_in;
   logic [7:0]    fabric_out = 8'h3C; // fabric data for bypass
   logic [7:0]    ext_val = 8'hA5;    // board drive level
   logic [7:0]    ext_en = 8'h00;     // board drive enable
   logic          port_irq;
   logic [1:0]    usb_out, usb_oe, usb_pu;
   logic [1:0]    usb_in = 2'b10;       // usb pad levels from the board
   logic [1:0]    usb_core_out = 2'b00; // usb core drive data
   logic [1:0]    usb_core_oe = 2'b00;  // usb core drive enable
   logic [3:0]    e;                  // expected {out, oe, pu, pd}
   int            err_total = 0;
   int            n_checks = 0;
   always #12.5 clock = ~clock;
   pdm_port i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pu(pad_pu), .pad_pd(pad_pd), .fabric_out(fabric_out), .fabric_in(fabric_in), .port_irq(port_irq),
      .usb_pad_in(usb_in), .usb_pad_out(usb_out), .usb_pad_oe(usb_oe), .usb_pad_pu(usb_pu),
      .usb_core_out(usb_core_out), .usb_core_oe(usb_core_oe));
   pdm_board i_board (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
      .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // pad legs per mode; out only counts while the strong leg is on
   function automatic logic [3:0] leg(input logic [2:0] m, input logic d);
      case (m)
         3'h2: leg = {1'b0, ~d, d, 1'b0};
         3'h3: leg = {d, d, 1'b0, ~d};
         3'h4: leg = {1'b0, ~d, 2'b00};
         3'h5: leg = {d, d, 2'b00};
         3'h6: leg = {d, 1'b1, 2'b00};
         3'h7: leg = {2'b00, d, ~d};
         default: leg = 4'h0;
      endcase
   endfunction
   initial
   begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      cyc(2);
      chk({pad_oe, pad_pu, pad_pd, fabric_in}, 32'h0);
      rd(8'hFC);
      chk(rd_v, 32'h0);
      for (int m = 0; m < 8; m++)
         for (int d = 0; d < 2; d++)
         begin
            wr(ADDR_DR, {24'h0, {8{d[0]}}});
            wr(ADDR_DM0, {24'h0, {8{m[0]}}});
            wr(ADDR_DM1, {24'h0, {8{m[1]}}});
            wr(ADDR_DM2, {24'h0, {8{m[2]}}});
            cyc(2);
            e = leg(m[2:0], d[0]);
            chk({pad_out & pad_oe, pad_oe, pad_pu, pad_pd}, {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}});
         end
      $display("test drive modes done");
      wr(ADDR_DM0, 32'h0);
      wr(ADDR_BYP, 32'hF0);
      wr(ADDR_DR, 32'h55);
      cyc(2);
      chk(pad_out, 8'h35);
      wr(ADDR_DM0, 32'hFE);
      wr(ADDR_DM1, 32'h0);
      wr(ADDR_DM2, 32'h0);
      wr(ADDR_ROUTE, 32'hFF);
      ext_en <= 8'hFF;
      cyc(10);
      rd(ADDR_PS);
      chk(rd_v, 32'hA4);
      rd(ADDR_DR);
      chk(rd_v, 32'h55);
      chk(fabric_in, 8'hA4);
      $display("test pin state done");
      wr(ADDR_RISE, 32'h02);
      wr(ADDR_FALL, 32'h06);
      ext_val <= 8'hB3;
      cyc(12);
      rd(ADDR_INTST);
      chk(rd_v, 32'h06);
      chk(port_irq, 1'b1);
      cyc(8);
      rd(ADDR_INTST);
      chk(rd_v, 32'h06);
      wr(ADDR_INTST, 32'h06);
      ext_val <= 8'hA5;
      cyc(12);
      rd(ADDR_INTST);
      chk(rd_v, 32'h02);
      chk(port_irq, 1'b1);
      wr(ADDR_INTST, 32'h02);
      rd(ADDR_INTST);
      chk(rd_v, 32'h0);
      chk(port_irq, 1'b0);
      $display("test edges done");
      wr(ADDR_PIN0 + 8'h08, 32'h0D);
      cyc(2);
      chk({pad_out[2], pad_oe[2]}, 2'b11);
      rd(ADDR_DM1);
      chk(rd_v, 32'h04);
      wr(ADDR_USB, 32'h66);
      cyc(2);
      chk({usb_out, usb_oe, usb_pu}, 6'h3C);
      wr(ADDR_USB, 32'h38);
      wr(ADDR_DM0, 32'hFF);
      cyc(2);
      chk({usb_out, usb_oe, usb_pu}, 6'h09);
      rd(ADDR_USB);
      chk(rd_v, 32'h138);
      wr(ADDR_USB, 32'h1F);
      usb_core_out <= 2'b10;
      usb_core_oe <= 2'b11;
      cyc(2);
      chk({usb_out, usb_oe, usb_pu}, 6'h2C);
      wr(ADDR_DM1, 32'hFF);
      wr(ADDR_DM2, 32'hFF);
      wr(ADDR_REGOUT, 32'h0F);
      cyc(2);
      chk({pad_oe, pad_pu, pad_pd}, 24'h0030C0);
      wr(ADDR_RSTDM, 32'h924924);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_DM2);
      chk(rd_v, 32'hFF);
      rd(ADDR_DM0);
      chk(rd_v, 32'h0);
      $display("test pin form, usb, regulated and reload done");
      final_report();
   end
   // hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      #(3000 * 25);
      err_total++;
      final_report();
   end
endmodule
